// File: src/cft_params.svh
// timing, vector, field and frame constants of the fault and trace sequencer
// assumes inclusion by the sequencer and its frame writer only
//
// Functional notes
// - privileged ops in user state raise violation
// - trace bit at start traces after completion
// - no trace for untaken, illegal or privileged
// - no trace after reset, bus or address abort
// - trace goes before a pending interrupt
// - forced trap, then trace, then interrupt
// - bus error aborts cycle, starts exception at once
// - copy status, set supervisor, clear trace
// - stacked pc one to five words past start; here always one word
// - frame holds word, address, direction, flag, class
// - direction write 0 read 1; instruction 0
// - flag instruction for normal or group 2
// - resume at vector two; handler cleans stack
// - bus error in group 0 processing halts
// - only reset restarts a halted device
// - odd word, long or fetch address errors
// - address error reuses sequence, own vector
// - address error in group 0 processing halts
// - address error runs short aborted cycle first
// - early silicon also asserts both byte strobes
`ifndef CFT_PARAMS_SVH
`define CFT_PARAMS_SVH

`define CFT_ADDR_W 24
`define CFT_SW_TRACE_BIT 15
`define CFT_SW_SUPER_BIT 13
`define CFT_VEC_BUS_ERR 8'h02
`define CFT_VEC_ADDR_ERR 8'h03
`define CFT_VEC_NONE 8'h00
`define CFT_PC_ADVANCE 24'h000002
`define CFT_SHORT_CYC 2'h2
`define CFT_FRAME_LAST 3'h6
`define CFT_DESC_RW_BIT 4
`define CFT_DESC_IN_BIT 3
`define CFT_RW_WRITE 1'b0
`define CFT_RW_READ 1'b1
`define CFT_IN_INSTR 1'b0
`define CFT_IN_NOT 1'b1

`endif

// File: src/cft_pkg.sv
// types shared by the fault and trace sequencer files
// assumes nothing beyond compile order
package cft_pkg;

  // decoded class of the instruction about to run
  typedef enum logic [3:0] {
    OP_NORMAL, OP_STOP, OP_RESET, OP_RTE, OP_MOVE_TO_SW,
    OP_AND_IMM_SW, OP_EOR_IMM_SW, OP_OR_IMM_SW, OP_MOVE_USP, OP_ILLEGAL
  } cft_op_t;

  // exception handed to the core
  typedef enum logic [2:0] {
    EXC_NONE, EXC_PRIV, EXC_TRAP, EXC_TRACE, EXC_BUS_ERR, EXC_ADDR_ERR
  } cft_exc_t;

  typedef enum logic [2:0] {
    ST_RESET_EXC, ST_IDLE, ST_ABORT, ST_STACK, ST_VECTOR, ST_HALT
  } cft_state_t;

endpackage : cft_pkg

// File: src/cft_frame_stack.sv
// writes the seven-word group 0 frame, highest word first
// assumes the core predecrements the supervisor stack per write
`timescale 1ns/1ps
`include "cft_params.svh"

module cft_frame_stack (
  // clock and reset
  input logic i_sys_clk,
  input logic i_rst,
  // frame contents, word 0 at lowest address
  input logic i_start,
  input logic [7*16-1:0] i_words,
  // stack write port
  output logic o_we,
  output logic [2:0] o_idx,
  output logic [15:0] o_data,
  output logic o_done
);

  logic busy_reg, busy_next;
  logic [2:0] idx_reg, idx_next;
  logic we_next, done_next;
  logic [15:0] data_next;

  always_comb begin
    busy_next = busy_reg;
    idx_next = idx_reg;
    we_next = 1'b0;
    done_next = 1'b0;
    data_next = o_data;
    if (i_start) begin
      busy_next = 1'b1;
      idx_next = `CFT_FRAME_LAST;
    end else if (busy_reg) begin
      we_next = 1'b1;
      data_next = i_words[idx_reg*16 +: 16];
      if (idx_reg == 3'h0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        idx_next = idx_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      idx_reg <= 3'h0;
      o_we <= 1'b0;
      o_idx <= 3'h0;
      o_data <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      idx_reg <= idx_next;
      o_we <= we_next;
      o_idx <= idx_reg;
      o_data <= data_next;
      o_done <= done_next;
    end
  end

endmodule : cft_frame_stack

// File: src/cft_exc_seq.sv
// fault and trace exception sequencer of the processor core
// assumes core decode, bus engine and stack writer on i_sys_clk
`timescale 1ns/1ps
`include "cft_params.svh"

module cft_exc_seq #(
  parameter bit EARLY_MASK_STROBES = 1'b0
) (
  // clock and reset
  input logic i_sys_clk,
  input logic i_rst,
  // instruction flow from the core
  input logic i_instr_start,
  input cft_pkg::cft_op_t i_op_kind,
  input logic [15:0] i_instr_word,
  input logic [`CFT_ADDR_W-1:0] i_instr_pc,
  input logic i_instr_done,
  input logic i_instr_forced,
  input logic [15:0] i_processor_status_word,
  input logic i_grp1_active,
  input logic i_reset_exc_done,
  input logic i_exc_ack,
  // bus access in progress
  input logic i_bus_active,
  input logic [`CFT_ADDR_W-1:0] i_bus_addr,
  input logic i_bus_read,
  input logic i_bus_wide,
  input logic i_bus_fetch,
  input logic [2:0] i_bus_fc,
  input logic i_bus_err_n,
  // exception requests
  output logic o_exc_req,
  output cft_pkg::cft_exc_t o_exc_kind,
  output logic [7:0] o_exc_vector,
  output logic o_irq_allow,
  output logic o_halted,
  // status word update
  output logic o_sw_write,
  output logic [15:0] o_sw_value,
  // aborted and short bus cycle
  output logic o_abort_cycle,
  output logic o_address_valid_strobe,
  output logic o_upper_byte_strobe,
  output logic o_lower_byte_strobe,
  // frame stack writes
  output logic o_frame_we,
  output logic [2:0] o_frame_idx,
  output logic [15:0] o_frame_data
);

  ////////////////////////////////////////////////////////////////////////
  // bus error pin synchroniser

  logic berr_s1_reg, berr_s2_reg, berr_prev_reg;
  logic be_evt, ae_evt;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      berr_s1_reg <= 1'b0;
      berr_s2_reg <= 1'b0;
      berr_prev_reg <= 1'b0;
    end else begin
      berr_s1_reg <= ~i_bus_err_n;
      berr_s2_reg <= berr_s1_reg;
      berr_prev_reg <= berr_s2_reg;
    end
  end

  assign be_evt = berr_s2_reg & ~berr_prev_reg & i_bus_active;
  assign ae_evt = i_bus_active & (i_bus_wide | i_bus_fetch) & i_bus_addr[0];

  ////////////////////////////////////////////////////////////////////////
  // sequencer state

  cft_pkg::cft_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic trace_armed_reg, trace_armed_next;
  logic pend_priv_reg, pend_priv_next;
  logic pend_trap_reg, pend_trap_next;
  logic pend_trace_reg, pend_trace_next;
  logic busy_reg, busy_next;
  logic addr_err_reg, addr_err_next;
  logic frame_start_reg, frame_start_next;
  logic [15:0] cur_iw_reg, cur_iw_next;
  logic [`CFT_ADDR_W-1:0] cur_pc_reg, cur_pc_next;
  logic [15:0] desc_reg, desc_next;
  logic [`CFT_ADDR_W-1:0] fault_addr_reg, fault_addr_next;
  logic [15:0] sw_copy_reg, sw_copy_next;
  logic exc_req_next, irq_allow_next, halted_next, sw_write_next;
  logic abort_next, as_next, ub_next, lb_next;
  cft_pkg::cft_exc_t exc_kind_next;
  logic [7:0] vec_next;
  logic [15:0] sw_value_next;
  logic frame_done, grp0, user_priv;
  logic [7*16-1:0] frame_words;

  assign grp0 = (state_reg == cft_pkg::ST_RESET_EXC) || (state_reg == cft_pkg::ST_ABORT)
      || (state_reg == cft_pkg::ST_STACK) || (state_reg == cft_pkg::ST_VECTOR);
  assign user_priv = ~i_processor_status_word[`CFT_SW_SUPER_BIT]
      && (i_op_kind != cft_pkg::OP_NORMAL) && (i_op_kind != cft_pkg::OP_ILLEGAL);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    trace_armed_next = trace_armed_reg;
    pend_priv_next = pend_priv_reg;
    pend_trap_next = pend_trap_reg;
    pend_trace_next = pend_trace_reg;
    busy_next = busy_reg;
    addr_err_next = addr_err_reg;
    frame_start_next = 1'b0;
    cur_iw_next = cur_iw_reg;
    cur_pc_next = cur_pc_reg;
    desc_next = desc_reg;
    fault_addr_next = fault_addr_reg;
    sw_copy_next = sw_copy_reg;
    exc_req_next = o_exc_req;
    exc_kind_next = o_exc_kind;
    vec_next = o_exc_vector;
    halted_next = 1'b0;
    sw_write_next = 1'b0;
    sw_value_next = o_sw_value;
    abort_next = 1'b0;
    as_next = 1'b0;
    ub_next = 1'b0;
    lb_next = 1'b0;
    case (state_reg)
      cft_pkg::ST_RESET_EXC: begin
        if (be_evt || ae_evt) begin
          state_next = cft_pkg::ST_HALT;
        end else if (i_reset_exc_done) begin
          state_next = cft_pkg::ST_IDLE;
        end
      end
      cft_pkg::ST_IDLE: begin
        if (be_evt || ae_evt) begin
          abort_next = 1'b1;
          addr_err_next = ae_evt;
          trace_armed_next = 1'b0;
          pend_priv_next = 1'b0;
          pend_trap_next = 1'b0;
          pend_trace_next = 1'b0;
          busy_next = 1'b0;
          exc_req_next = 1'b0;
          sw_copy_next = i_processor_status_word;
          sw_write_next = 1'b1;
          sw_value_next = i_processor_status_word;
          sw_value_next[`CFT_SW_SUPER_BIT] = 1'b1;
          sw_value_next[`CFT_SW_TRACE_BIT] = 1'b0;
          fault_addr_next = i_bus_addr;
          desc_next = 16'h0000;
          desc_next[2:0] = i_bus_fc;
          desc_next[`CFT_DESC_RW_BIT] = i_bus_read ? `CFT_RW_READ : `CFT_RW_WRITE;
          desc_next[`CFT_DESC_IN_BIT] = i_grp1_active ? `CFT_IN_NOT : `CFT_IN_INSTR;
          if (ae_evt) begin
            state_next = cft_pkg::ST_ABORT;
            cnt_next = `CFT_SHORT_CYC;
          end else begin
            state_next = cft_pkg::ST_STACK;
            frame_start_next = 1'b1;
          end
        end else begin
          if (busy_reg) begin
            if (i_exc_ack) begin
              busy_next = 1'b0;
              exc_req_next = 1'b0;
              case (o_exc_kind)
                cft_pkg::EXC_PRIV: pend_priv_next = 1'b0;
                cft_pkg::EXC_TRAP: pend_trap_next = 1'b0;
                default: pend_trace_next = 1'b0;
              endcase
            end
          end else if (pend_priv_reg || pend_trap_reg || pend_trace_reg) begin
            busy_next = 1'b1;
            exc_req_next = 1'b1;
            vec_next = `CFT_VEC_NONE;
            if (pend_priv_reg) begin
              exc_kind_next = cft_pkg::EXC_PRIV;
            end else if (pend_trap_reg) begin
              exc_kind_next = cft_pkg::EXC_TRAP;
            end else begin
              exc_kind_next = cft_pkg::EXC_TRACE;
            end
          end
          if (i_instr_start) begin
            cur_iw_next = i_instr_word;
            cur_pc_next = i_instr_pc;
            trace_armed_next = i_processor_status_word[`CFT_SW_TRACE_BIT];
            if (user_priv || (i_op_kind == cft_pkg::OP_ILLEGAL)) begin
              trace_armed_next = 1'b0;
            end
            if (user_priv) begin
              pend_priv_next = 1'b1;
            end
          end else if (i_instr_done) begin
            if (i_instr_forced) begin
              pend_trap_next = 1'b1;
            end
            if (trace_armed_reg) begin
              pend_trace_next = 1'b1;
            end
            trace_armed_next = 1'b0;
          end
        end
      end
      cft_pkg::ST_ABORT: begin
        if (be_evt || ae_evt) begin
          state_next = cft_pkg::ST_HALT;
        end else if (cnt_reg == 2'h0) begin
          state_next = cft_pkg::ST_STACK;
          frame_start_next = 1'b1;
        end else begin
          as_next = 1'b1;
          ub_next = EARLY_MASK_STROBES;
          lb_next = EARLY_MASK_STROBES;
          cnt_next = cnt_reg - 2'h1;
        end
      end
      cft_pkg::ST_STACK: begin
        if (be_evt || ae_evt) begin
          state_next = cft_pkg::ST_HALT;
        end else if (frame_done) begin
          state_next = cft_pkg::ST_VECTOR;
          exc_req_next = 1'b1;
          exc_kind_next = addr_err_reg ? cft_pkg::EXC_ADDR_ERR : cft_pkg::EXC_BUS_ERR;
          vec_next = addr_err_reg ? `CFT_VEC_ADDR_ERR : `CFT_VEC_BUS_ERR;
        end
      end
      cft_pkg::ST_VECTOR: begin
        if (be_evt || ae_evt) begin
          state_next = cft_pkg::ST_HALT;
          exc_req_next = 1'b0;
        end else if (i_exc_ack) begin
          state_next = cft_pkg::ST_IDLE;
          exc_req_next = 1'b0;
        end
      end
      default: begin
        halted_next = 1'b1;
        exc_req_next = 1'b0;
      end
    endcase
    if (state_next == cft_pkg::ST_HALT) begin
      halted_next = 1'b1;
      exc_req_next = 1'b0;
    end
    irq_allow_next = (state_next == cft_pkg::ST_IDLE) && !pend_priv_next
        && !pend_trap_next && !pend_trace_next && !busy_next && !trace_armed_next;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= cft_pkg::ST_RESET_EXC;
      cnt_reg <= 2'h0;
      trace_armed_reg <= 1'b0;
      pend_priv_reg <= 1'b0;
      pend_trap_reg <= 1'b0;
      pend_trace_reg <= 1'b0;
      busy_reg <= 1'b0;
      addr_err_reg <= 1'b0;
      frame_start_reg <= 1'b0;
      cur_iw_reg <= 16'h0000;
      cur_pc_reg <= 24'h000000;
      desc_reg <= 16'h0000;
      fault_addr_reg <= 24'h000000;
      sw_copy_reg <= 16'h0000;
      o_exc_req <= 1'b0;
      o_exc_kind <= cft_pkg::EXC_NONE;
      o_exc_vector <= `CFT_VEC_NONE;
      o_irq_allow <= 1'b0;
      o_halted <= 1'b0;
      o_sw_write <= 1'b0;
      o_sw_value <= 16'h0000;
      o_abort_cycle <= 1'b0;
      o_address_valid_strobe <= 1'b0;
      o_upper_byte_strobe <= 1'b0;
      o_lower_byte_strobe <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trace_armed_reg <= trace_armed_next;
      pend_priv_reg <= pend_priv_next;
      pend_trap_reg <= pend_trap_next;
      pend_trace_reg <= pend_trace_next;
      busy_reg <= busy_next;
      addr_err_reg <= addr_err_next;
      frame_start_reg <= frame_start_next;
      cur_iw_reg <= cur_iw_next;
      cur_pc_reg <= cur_pc_next;
      desc_reg <= desc_next;
      fault_addr_reg <= fault_addr_next;
      sw_copy_reg <= sw_copy_next;
      o_exc_req <= exc_req_next;
      o_exc_kind <= exc_kind_next;
      o_exc_vector <= vec_next;
      o_irq_allow <= irq_allow_next;
      o_halted <= halted_next;
      o_sw_write <= sw_write_next;
      o_sw_value <= sw_value_next;
      o_abort_cycle <= abort_next;
      o_address_valid_strobe <= as_next;
      o_upper_byte_strobe <= ub_next;
      o_lower_byte_strobe <= lb_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // group 0 frame

  logic [`CFT_ADDR_W-1:0] stacked_pc;
  // one word past the first word
  assign stacked_pc = cur_pc_reg + `CFT_PC_ADVANCE;
  // seven words, descriptor at index 0
  assign frame_words = {stacked_pc[15:0], 8'h00, stacked_pc[23:16], sw_copy_reg, cur_iw_reg,
      fault_addr_reg[15:0], 8'h00, fault_addr_reg[23:16], desc_reg};

  cft_frame_stack u_frame (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(frame_start_reg),
    .i_words(frame_words),
    .o_we(o_frame_we),
    .o_idx(o_frame_idx),
    .o_data(o_frame_data),
    .o_done(frame_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_short_cycle;
    o_address_valid_strobe [*2] ##1 !o_address_valid_strobe;
  endsequence

  sequence s_vector_issue;
    o_exc_req && (o_exc_vector == (addr_err_reg ? `CFT_VEC_ADDR_ERR : `CFT_VEC_BUS_ERR));
  endsequence

  property p_priv;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_IDLE && !be_evt && !ae_evt && i_instr_start && user_priv)
        |=> pend_priv_reg && !trace_armed_reg;
  endproperty
  a_priv: assert property (p_priv) else $error("privileged op not trapped");

  property p_trace;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_IDLE && !be_evt && !ae_evt && !i_instr_start && i_instr_done
        && trace_armed_reg) |=> pend_trace_reg ##[0:20] (o_exc_kind == cft_pkg::EXC_TRACE);
  endproperty
  a_trace: assert property (p_trace) else $error("trace not raised");

  property p_illegal_untraced;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_IDLE && !be_evt && !ae_evt && i_instr_start
        && i_op_kind == cft_pkg::OP_ILLEGAL) |=> !trace_armed_reg;
  endproperty
  a_illegal_untraced: assert property (p_illegal_untraced) else $error("illegal op traced");

  property p_abort_untraced;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_IDLE && (be_evt || ae_evt))
        |=> !pend_trace_reg && !trace_armed_reg && !o_irq_allow;
  endproperty
  a_abort_untraced: assert property (p_abort_untraced) else $error("trace after abort");

  property p_irq_after_trace;
    @(posedge i_sys_clk) disable iff (i_rst)
    pend_trace_reg |-> !o_irq_allow;
  endproperty
  a_irq_after_trace: assert property (p_irq_after_trace) else $error("irq before trace");

  property p_trap_first;
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_exc_req && o_exc_kind == cft_pkg::EXC_TRACE) |-> !pend_trap_reg && !pend_priv_reg;
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trace before trap");

  property p_entry_sw;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_IDLE && be_evt && !ae_evt) |=> o_abort_cycle && o_sw_write
        && o_sw_value[`CFT_SW_SUPER_BIT] && !o_sw_value[`CFT_SW_TRACE_BIT]
        && state_reg == cft_pkg::ST_STACK;
  endproperty
  a_entry_sw: assert property (p_entry_sw) else $error("bad bus error entry");

  property p_vector;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_STACK && frame_done && !be_evt && !ae_evt) |=> s_vector_issue;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong group 0 vector");

  property p_double_fault;
    @(posedge i_sys_clk) disable iff (i_rst)
    (grp0 && (be_evt || ae_evt)) |=> o_halted [*3];
  endproperty
  a_double_fault: assert property (p_double_fault) else $error("double fault not halted");

  property p_short;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == cft_pkg::ST_IDLE && ae_evt) |=> ##1 s_short_cycle;
  endproperty
  a_short: assert property (p_short) else $error("short cycle wrong");

endmodule : cft_exc_seq

// File: tb/cft_bus_err_src.sv
// external bus control model that raises bus error requests
// assumes fire and hold come from the bench between clock edges
`timescale 1ns/1ps

module cft_bus_err_src (
  // clock
  input wire logic i_sys_clk,
  // request from the bench
  input wire logic i_fire,
  input wire logic [1:0] i_hold,
  // error pin, active low, pulled up when released
  output logic o_bus_err_n
);
  logic [2:0] cnt_reg = 3'h0;

  always @(posedge i_sys_clk) begin
    if (i_fire) begin
      cnt_reg <= {1'b0, i_hold} + 3'h2;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  assign o_bus_err_n = (cnt_reg == 3'h0);
endmodule : cft_bus_err_src

// File: tb/cft_exc_seq_test.sv
// self-checking bench of the fault and trace sequencer
// assumes the bus error model cft_bus_err_src
`timescale 1ns/1ps

module cft_exc_seq_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic st = 1'b0, dn = 1'b0, frc = 1'b0, g1 = 1'b0, rdn = 1'b0, ack = 1'b0;
  logic ba = 1'b0, rd = 1'b0, wi = 1'b0, fe = 1'b0, fire = 1'b0, err_n;
  logic [1:0] hold = 2'h0;
  logic [2:0] fc = 3'h0;
  logic [15:0] wd = 16'h0, sw = 16'h0;
  logic [23:0] pc = 24'h0, ad = 24'h0;
  cft_pkg::cft_op_t op = cft_pkg::OP_NORMAL;
  cft_pkg::cft_op_t k;
  logic o_exc_req, o_irq_allow, o_halted, o_sw_write, o_abort_cycle;
  logic o_address_valid_strobe, o_upper_byte_strobe, o_lower_byte_strobe, o_frame_we;
  cft_pkg::cft_exc_t o_exc_kind;
  logic [7:0] o_exc_vector;
  logic [15:0] o_sw_value, o_frame_data;
  logic [2:0] o_frame_idx;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  cft_bus_err_src u_err (.i_sys_clk(clk), .i_fire(fire), .i_hold(hold), .o_bus_err_n(err_n));

  cft_exc_seq #(.EARLY_MASK_STROBES(1'b1)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_instr_start(st), .i_op_kind(op), .i_instr_word(wd),
    .i_instr_pc(pc), .i_instr_done(dn), .i_instr_forced(frc), .i_processor_status_word(sw),
    .i_grp1_active(g1), .i_reset_exc_done(rdn), .i_exc_ack(ack), .i_bus_active(ba),
    .i_bus_addr(ad), .i_bus_read(rd), .i_bus_wide(wi), .i_bus_fetch(fe), .i_bus_fc(fc),
    .i_bus_err_n(err_n), .o_exc_req(o_exc_req), .o_exc_kind(o_exc_kind),
    .o_exc_vector(o_exc_vector), .o_irq_allow(o_irq_allow), .o_halted(o_halted),
    .o_sw_write(o_sw_write), .o_sw_value(o_sw_value), .o_abort_cycle(o_abort_cycle),
    .o_address_valid_strobe(o_address_valid_strobe),
    .o_upper_byte_strobe(o_upper_byte_strobe), .o_lower_byte_strobe(o_lower_byte_strobe),
    .o_frame_we(o_frame_we), .o_frame_idx(o_frame_idx), .o_frame_data(o_frame_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic do_reset(input logic fin);
    rst = 1'b1;
    tick(3);
    chk("idle_outs", 24'h0, {o_exc_req, o_halted, o_sw_write, o_abort_cycle, o_frame_we});
    rst = 1'b0;
    tick(1);
    rdn = fin;
    tick(1);
    rdn = 1'b0;
  endtask : do_reset

  task automatic go(input cft_pkg::cft_op_t kk, input logic [15:0] s);
    op = kk;
    sw = s;
    wd = 16'($urandom);
    pc = 24'($urandom) & 24'hfffffe;
    st = 1'b1;
    tick(1);
    st = 1'b0;
  endtask : go

  task automatic get_req(input cft_pkg::cft_exc_t kk, input logic [7:0] v);
    int i;
    for (i = 0; i < 30 && o_exc_req !== 1'b1; i++) tick(1);
    chk("exc_req", 24'h1, o_exc_req);
    chk("exc_kind", kk, o_exc_kind);
    chk("exc_vector", v, o_exc_vector);
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
    tick(1);
  endtask : get_req

  task automatic run(input cft_pkg::cft_op_t kk, input logic [15:0] s, input logic f);
    logic p;
    logic w;
    p = kk != cft_pkg::OP_NORMAL && kk != cft_pkg::OP_ILLEGAL && !s[13];
    w = !(p || (s[15] && kk != cft_pkg::OP_ILLEGAL));
    go(kk, s);
    tick(1);
    chk("irq_armed", {23'h0, w}, o_irq_allow);
    if (p) get_req(cft_pkg::EXC_PRIV, 8'h00);
    else if (kk != cft_pkg::OP_ILLEGAL) begin
      tick($urandom_range(0, 3));
      frc = f;
      dn = 1'b1;
      tick(1);
      dn = 1'b0;
      frc = 1'b0;
      if (f) get_req(cft_pkg::EXC_TRAP, 8'h00);
      if (f && s[15]) chk("irq_trap", 24'h0, o_irq_allow);
      if (s[15]) get_req(cft_pkg::EXC_TRACE, 8'h00);
    end
    tick(2);
    chk("extra_req", 24'h0, o_exc_req);
    chk("irq_allow", 24'h1, o_irq_allow);
  endtask : run

  task automatic fault(input logic a, input logic dbl);
    int i;
    int j;
    logic [15:0] e [7];
    logic [23:0] q;
    go(cft_pkg::OP_NORMAL, {3'b100, 13'($urandom)});
    q = pc + 24'h000002;
    ad = {23'($urandom), a};
    rd = 1'($urandom);
    fe = 1'($urandom);
    wi = a | 1'($urandom);
    fc = 3'($urandom);
    g1 = 1'($urandom);
    e = '{{11'h0, rd, g1, fc}, {8'h0, ad[23:16]}, ad[15:0], wd, sw, {8'h0, q[23:16]}, q[15:0]};
    ba = 1'b1;
    fire = !a;
    hold = 2'($urandom);
    tick(1);
    fire = 1'b0;
    if (a) ba = 1'b0;
    for (i = 0; i < 10 && o_abort_cycle !== 1'b1; i++) tick(1);
    ba = 1'b0;
    chk("abort", 24'h1, o_abort_cycle);
    chk("sw_write", 24'h1, o_sw_write);
    chk("sw_value", (sw | 16'h2000) & 16'h7fff, o_sw_value);
    if (a) begin
      tick(1);
      chk("addr_strobe", 24'h1, o_address_valid_strobe);
      chk("byte_strobes", 24'h3, {o_upper_byte_strobe, o_lower_byte_strobe});
    end
    if (dbl) begin
      tick(4);
      ba = 1'b1;
      fire = !a;
      tick(1);
      fire = 1'b0;
      if (a) ba = 1'b0;
      tick(12);
      ba = 1'b0;
      if (a) chk("halted", 24'h1, o_halted);
      else chk("halted", 24'h1, o_halted);
      go(cft_pkg::OP_STOP, 16'h0);
      tick(3);
      chk("halt_req", 24'h0, o_exc_req);
    end else begin
      for (i = 6; i >= 0; i--) begin
        for (j = 0; j < 12 && o_frame_we !== 1'b1; j++) tick(1);
        chk("frame_idx", 24'(i), o_frame_idx);
        chk("frame_word", e[i], o_frame_data);
        tick(1);
      end
      if (a) get_req(cft_pkg::EXC_ADDR_ERR, 8'h03);
      else get_req(cft_pkg::EXC_BUS_ERR, 8'h02);
      tick(2);
      chk("trace_after_fault", 24'h0, o_exc_req);
    end
    g1 = 1'b0;
  endtask : fault

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    void'($urandom(32));
    do_reset(1'b1);
    for (int n = 0; n < 10; n++) run(cft_pkg::cft_op_t'(n), 16'($urandom) & 16'h5fff, 1'b0);
    run(cft_pkg::OP_NORMAL, 16'h8000, 1'b0);
    run(cft_pkg::OP_NORMAL, 16'ha000, 1'b1);
    run(cft_pkg::OP_RTE, 16'h8000, 1'b0);
    run(cft_pkg::OP_ILLEGAL, 16'h8000, 1'b0);
    repeat (30) begin
      k = cft_pkg::cft_op_t'($urandom_range(0, 9));
      run(k, 16'($urandom), k == cft_pkg::OP_NORMAL && 1'($urandom));
    end
    fault(1'b0, 1'b0);
    fault(1'b1, 1'b0);
    fault(1'b1, 1'b1);
    do_reset(1'b1);
    fault(1'b0, 1'b1);
    do_reset(1'b0);
    ad = 24'h000101;
    wi = 1'b1;
    ba = 1'b1;
    tick(1);
    ba = 1'b0;
    tick(8);
    chk("reset_phase_halt", 24'h1, o_halted);
    do_reset(1'b1);
    run(cft_pkg::OP_NORMAL, 16'h8000, 1'b0);
    test_done();
  end
endmodule : cft_exc_seq_test
